// File: hw/vrid_cfg.svh
// Purpose: Offsets, reset values and field positions of the regulator identity bank
// Assumes: Byte-wide register port, one 50 MHz clock
// Notes: Values here are fixed by the regulator definition; identity value is arbitrary
// Function
// - Offset 02h returns a vendor code naming the controller chip revision.
// - Offset 05h returns 01h, the supported voltage-ID protocol version.
// - Offset 06h capability byte reads C7h, one bit per supported feature.
// - Capability bit 7 set: current register full scale FFh equals maximum load.
// - Capability bit 6 reads 1: temperature ADC measurement supported.
// - Capability bits 1 and 0 read 1: output voltage and current ADC supported.
// - Capability bit 3 reads 0: input-voltage ADC measurement not supported.
// - Status at 10h resets to 00h; master reads it after alert assertion.
// - Full-scale format: current register at 15h reads FFh at 2 V monitor voltage.
`ifndef VRID_CFG_SVH
`define VRID_CFG_SVH

`define VRID_OFS_REVISION     8'h02
`define VRID_OFS_PROTOCOL     8'h05
`define VRID_OFS_CAPABILITY   8'h06
`define VRID_OFS_STATUS       8'h10
`define VRID_OFS_CURRENT      8'h15

`define VRID_PROTOCOL_VALUE   8'h01
`define VRID_STATUS_RESET     8'h00
`define VRID_CURRENT_RESET    8'h01
`define VRID_READ_UNMAPPED    8'h00

`define VRID_CAP_IOUT_FORMAT  7
`define VRID_CAP_TEMP_ADC     6
`define VRID_CAP_VIN_ADC      3
`define VRID_CAP_VOUT_ADC     1
`define VRID_CAP_IOUT_ADC     0
`define VRID_CAPABILITY_VALUE 8'hc7

`define VRID_FULL_SCALE_CODE  8'hff

`endif

// File: hw/vrid_pkg.sv
// Purpose: Types shared by the regulator identity bank
// Assumes: Included constants header gives all numeric values
// Notes: Types only
package vrid_pkg;
	typedef logic [7:0] vrid_byte_t;
	typedef enum logic [2:0] {
		VRID_SEL_REVISION,
		VRID_SEL_PROTOCOL,
		VRID_SEL_CAPABILITY,
		VRID_SEL_STATUS,
		VRID_SEL_CURRENT,
		VRID_SEL_NONE
	} vrid_sel_t;
endpackage : vrid_pkg

// File: hw/vrid_regs.sv
// Purpose: Read-only identity, capability, status and current registers of a regulator
// Assumes: Register port driven by the serial bus front end on the same clock
// Notes: Status conditions arrive from pins; current code from an on-chip ADC
`timescale 1ns/10ps
module vrid_regs #(
	parameter logic [7:0] REVISION_CODE = 8'h5a, // Arbitrary value
	parameter int         ADC_BITS      = 10
) (
	input  wire logic                 clock,
	input  wire logic                 arst_n,
	input  wire logic                 clk_en,
	input  wire logic                 rd_stb,
	input  wire logic                 wr_stb,
	input  wire vrid_pkg::vrid_byte_t addr,
	input  wire vrid_pkg::vrid_byte_t wdata,
	input  wire vrid_pkg::vrid_byte_t status_pins,
	input  wire logic [ADC_BITS-1:0]  current_monitor_pin,
	input  wire logic                 current_valid,
	output vrid_pkg::vrid_byte_t      rdata_reg,
	output logic                      rd_ack_reg,
	output logic                      wr_ack_reg,
	output logic                      alert_n_reg
);
	import vrid_pkg::*;
	`include "vrid_cfg.svh"

	logic       rst_meta_reg;
	logic       rst_sync_reg;
	vrid_byte_t pins_meta_reg;
	vrid_byte_t pins_sync_reg;
	vrid_byte_t status_val;
	logic       alert_req;
	logic       status_read;
	vrid_byte_t current_reg;
	vrid_byte_t current_next;
	vrid_byte_t capability;
	vrid_sel_t  sel;

	function automatic vrid_sel_t decode(input vrid_byte_t a);
		case (a)
			`VRID_OFS_REVISION:   decode = VRID_SEL_REVISION;
			`VRID_OFS_PROTOCOL:   decode = VRID_SEL_PROTOCOL;
			`VRID_OFS_CAPABILITY: decode = VRID_SEL_CAPABILITY;
			`VRID_OFS_STATUS:     decode = VRID_SEL_STATUS;
			`VRID_OFS_CURRENT:    decode = VRID_SEL_CURRENT;
			default:              decode = VRID_SEL_NONE;
		endcase
	endfunction : decode

	// Reset released through two flops; assertion stays asynchronous
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			pins_meta_reg <= `VRID_STATUS_RESET;
			pins_sync_reg <= `VRID_STATUS_RESET;
		end else if (clk_en) begin
			pins_meta_reg <= status_pins;
			pins_sync_reg <= pins_meta_reg;
		end
	end

	// Capability is wired constant; writes can never reach it
	always_comb begin
		capability = `VRID_CAPABILITY_VALUE;
		capability[`VRID_CAP_IOUT_FORMAT] = 1'b1;
		capability[`VRID_CAP_TEMP_ADC] = 1'b1;
		capability[`VRID_CAP_VIN_ADC] = 1'b0;
		capability[`VRID_CAP_VOUT_ADC] = 1'b1;
		capability[`VRID_CAP_IOUT_ADC] = 1'b1;
	end

	assign sel = decode(addr);
	assign status_read = clk_en & rd_stb & (sel == VRID_SEL_STATUS);

	vrid_status u_status (
		.clock         (clock),
		.rst_n         (rst_sync_reg),
		.clk_en        (clk_en),
		.cond          (pins_sync_reg),
		.clear_on_read (status_read),
		.status_reg    (status_val),
		.alert_reg     (alert_req)
	);

	// ADC full-scale code is the 2 V point; top bits keep FFh there
	assign current_next = current_monitor_pin[ADC_BITS-1 -: 8];

	always_ff @(posedge clock or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			current_reg <= `VRID_CURRENT_RESET;
		end else if (clk_en && current_valid) begin
			current_reg <= current_next;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			rdata_reg <= `VRID_READ_UNMAPPED;
		end else if (clk_en && rd_stb) begin
			case (sel)
				VRID_SEL_REVISION:   rdata_reg <= REVISION_CODE;
				VRID_SEL_PROTOCOL:   rdata_reg <= `VRID_PROTOCOL_VALUE;
				VRID_SEL_CAPABILITY: rdata_reg <= capability;
				VRID_SEL_STATUS:     rdata_reg <= status_val;
				VRID_SEL_CURRENT:    rdata_reg <= current_reg;
				default:             rdata_reg <= `VRID_READ_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			rd_ack_reg <= 1'b0;
		end else if (clk_en) begin
			rd_ack_reg <= rd_stb;
		end
	end

	// Write without a read in the same cycle acknowledged so the bus never stalls, data dropped
	always_ff @(posedge clock or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			wr_ack_reg <= 1'b0;
		end else if (clk_en) begin
			wr_ack_reg <= wr_stb & ~rd_stb;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			alert_n_reg <= 1'b1;
		end else if (clk_en) begin
			alert_n_reg <= ~alert_req;
		end
	end
endmodule : vrid_regs

// File: hw/vrid_status.sv
// Purpose: Sticky primary status byte and alert request
// Assumes: Condition inputs already synchronised to clock
// Notes: A rising condition sets its bit; reading the byte clears it
`timescale 1ns/10ps
module vrid_status (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              clk_en,
	input  wire vrid_pkg::vrid_byte_t cond,
	input  wire logic              clear_on_read,
	output vrid_pkg::vrid_byte_t   status_reg,
	output logic                   alert_reg
);
	import vrid_pkg::*;
	`include "vrid_cfg.svh"

	vrid_byte_t cond_prev_reg;
	vrid_byte_t rise;
	vrid_byte_t status_next;

	assign rise = cond & ~cond_prev_reg;

	// Set wins over a clear landing in the same cycle, so no event is lost
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_bit
			assign status_next[i] = rise[i] | (status_reg[i] & ~clear_on_read);
		end
	endgenerate

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cond_prev_reg <= `VRID_STATUS_RESET;
		end else if (clk_en) begin
			cond_prev_reg <= cond;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= `VRID_STATUS_RESET;
		end else if (clk_en) begin
			status_reg <= status_next;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			alert_reg <= 1'b0;
		end else if (clk_en) begin
			alert_reg <= |status_next;
		end
	end
endmodule : vrid_status

// File: testbench/vrid_master_model.sv
// Purpose: Bus master stand-in issuing one-cycle read and write requests
// Assumes: Answer is registered on the taking edge and settled by the next falling edge
// Notes: Released address and data show inverted values, never the last ones
`timescale 1ns/10ps
module vrid_master_model (
	input wire logic                 clock,
	input wire vrid_pkg::vrid_byte_t rdata_reg,
	input wire logic                 rd_ack_reg,
	input wire logic                 wr_ack_reg,
	output logic                     rd_stb,
	output logic                     wr_stb,
	output vrid_pkg::vrid_byte_t     addr,
	output vrid_pkg::vrid_byte_t     wdata
);
	import vrid_pkg::*;
	initial begin
		rd_stb = 1'b0;
		wr_stb = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
	end
	task automatic xfer(input logic w, input vrid_byte_t a, input vrid_byte_t d,
		output vrid_byte_t q, output logic k);
		@(posedge clock);
		rd_stb <= !w;
		wr_stb <= w;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		rd_stb <= 1'b0;
		wr_stb <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
		// Settled answer, half a cycle after the taking edge
		@(negedge clock);
		k = w ? wr_ack_reg : rd_ack_reg;
		q = rdata_reg;
	endtask : xfer
endmodule : vrid_master_model

// File: testbench/vrid_regs_monitor.sv
// Purpose: Port checks of the identity bank
// Assumes: One clock, answers one cycle after the taking edge
// Notes: Bound to every vrid_regs
`timescale 1ns/10ps
module vrid_regs_monitor #(
	parameter logic [7:0] REVISION_CODE = 8'h5a
) (
	input wire logic                 clock,
	input wire logic                 arst_n,
	input wire logic                 clk_en,
	input wire logic                 rd_stb,
	input wire logic                 wr_stb,
	input wire vrid_pkg::vrid_byte_t addr,
	input wire vrid_pkg::vrid_byte_t rdata_reg,
	input wire logic                 rd_ack_reg,
	input wire logic                 wr_ack_reg
);
	import vrid_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence s_rd(a);
		clk_en && rd_stb && addr == a;
	endsequence
	AST_REV: assert property (s_rd(8'h02) |=> rdata_reg == REVISION_CODE)
		else $error("revision read wrong");
	AST_PROTO: assert property (s_rd(8'h05) |=> rdata_reg == 8'h01)
		else $error("protocol read wrong");
	AST_CAP: assert property (s_rd(8'h06) |=> rdata_reg == 8'hc7)
		else $error("capability read wrong");
	AST_CAP_BITS: assert property (s_rd(8'h06) |=> rdata_reg[7:6] == 2'h3 && !rdata_reg[3])
		else $error("capability bits wrong");
	AST_HOLD: assert property (!(clk_en && rd_stb) |=> $stable(rdata_reg))
		else $error("read data moved without a read");
	AST_WR: assert property (clk_en && wr_stb && !rd_stb |=> wr_ack_reg && !rd_ack_reg)
		else $error("write not acknowledged alone");
	AST_RD_ACK: assert property (clk_en && rd_stb |=> rd_ack_reg)
		else $error("read not acknowledged");
	AST_ACK_CAUSE: assert property (rd_ack_reg |-> $past(clk_en) && $past(rd_stb))
		else $error("read ack without request");
endmodule : vrid_regs_monitor
bind vrid_regs vrid_regs_monitor #(.REVISION_CODE(REVISION_CODE)) u_mon (.clock, .arst_n,
	.clk_en, .rd_stb, .wr_stb, .addr, .rdata_reg, .rd_ack_reg, .wr_ack_reg);

// File: testbench/vrid_regs_tb_top.sv
// Purpose: Self-checking bench of the regulator identity bank
// Assumes: Master model owns the register port
// Notes: Status and current inputs driven here
`timescale 1ns/10ps
module vrid_regs_tb_top;
	import vrid_pkg::*;
	localparam logic [7:0] REV = 8'h3c; // Arbitrary value
	logic       clock, arst_n, clk_en, rd_stb, wr_stb, rd_ack_reg, wr_ack_reg, alert_n_reg;
	logic       current_valid, k;
	vrid_byte_t addr, wdata, rdata_reg, status_pins, q;
	logic [9:0] current_monitor_pin;
	int         miscompares = 0;
	int         n_tests = 0;
	vrid_regs #(.REVISION_CODE(REV), .ADC_BITS(10)) uut (.clock, .arst_n, .clk_en, .rd_stb,
		.wr_stb, .addr, .wdata, .status_pins, .current_monitor_pin, .current_valid,
		.rdata_reg, .rd_ack_reg, .wr_ack_reg, .alert_n_reg);
	vrid_master_model m (.clock, .rdata_reg, .rd_ack_reg, .wr_ack_reg, .rd_stb, .wr_stb,
		.addr, .wdata);
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task automatic chk(input vrid_byte_t got, input vrid_byte_t exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input vrid_byte_t a, input vrid_byte_t exp);
		m.xfer(1'b0, a, 8'h00, q, k);
		chk({7'h00, k}, 8'h01);
		chk(q, exp);
	endtask : rd
	task automatic t_status;
		rd(8'h10, 8'h00);
		@(posedge clock);
		status_pins <= 8'h81;
		repeat (6) @(negedge clock);
		chk({7'h00, alert_n_reg}, 8'h00);
		rd(8'h10, 8'h81);
		@(posedge clock);
		status_pins <= 8'h00;
		rd(8'h10, 8'h00);
		chk({7'h00, alert_n_reg}, 8'h01);
		$display("status test done");
	endtask : t_status
	task automatic t_ids;
		rd(8'h02, REV);
		rd(8'h05, 8'h01);
		rd(8'h06, 8'hc7);
		$display("identity test done");
	endtask : t_ids
	task automatic t_writes;
		m.xfer(1'b1, 8'h06, 8'h00, q, k);
		chk({7'h00, k}, 8'h01);
		m.xfer(1'b1, 8'h02, 8'hff, q, k);
		m.xfer(1'b1, 8'h10, 8'hff, q, k);
		m.xfer(1'b1, 8'h11, 8'hff, q, k);
		rd(8'h11, 8'h00);
		rd(8'h06, 8'hc7);
		rd(8'h02, REV);
		rd(8'h10, 8'h00);
		$display("write test done");
	endtask : t_writes
	task automatic t_current;
		@(posedge clock);
		current_monitor_pin <= 10'h3ff;
		current_valid <= 1'b1;
		@(posedge clock);
		current_valid <= 1'b0;
		rd(8'h15, 8'hff);
		$display("current test done");
	endtask : t_current
	// Pin change while frozen must not reach status until the enable returns
	task automatic t_freeze;
		@(posedge clock);
		clk_en <= 1'b0;
		status_pins <= 8'h04;
		repeat (8) @(negedge clock);
		chk({7'h00, alert_n_reg}, 8'h01);
		@(posedge clock);
		clk_en <= 1'b1;
		repeat (6) @(negedge clock);
		chk({7'h00, alert_n_reg}, 8'h00);
		rd(8'h10, 8'h04);
		$display("freeze test done");
	endtask : t_freeze
	// Pins drop during reset so no false rise follows the release
	task automatic t_reset;
		@(posedge clock);
		status_pins <= 8'h10;
		repeat (6) @(negedge clock);
		chk({7'h00, alert_n_reg}, 8'h00);
		@(posedge clock);
		arst_n <= 1'b0;
		status_pins <= 8'h00;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		repeat (2) @(posedge clock);
		rd(8'h10, 8'h00);
		chk({7'h00, alert_n_reg}, 8'h01);
		rd(8'h15, 8'h01);
		$display("reset test done");
	endtask : t_reset
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test
	initial begin
		arst_n = 1'b0;
		clk_en = 1'b1;
		status_pins = 8'h00;
		current_monitor_pin = 10'h000;
		current_valid = 1'b0;
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		repeat (2) @(posedge clock);
		t_status;
		t_ids;
		t_writes;
		t_current;
		t_freeze;
		t_reset;
		finish_test;
	end
	// About a hundred cycles of traffic, so ten times that is ample
	initial begin
		#20000;
		miscompares++;
		finish_test;
	end
endmodule : vrid_regs_tb_top
